/* File: core/uncore_counters_pkg.sv */
// package: register addresses, field positions and reset values of the event counter bank
// assumes 64-bit model register accesses addressed by the full register index
package uncore_counters_pkg;

  localparam int reg_addr_width = 20;
  localparam logic [19:0] addr_bus_queue_0 = 20'h107cc;
  localparam logic [19:0] addr_bus_queue_1 = 20'h107cd;
  localparam logic [19:0] addr_snoop_queue_0 = 20'h107ce;
  localparam logic [19:0] addr_snoop_queue_1 = 20'h107cf;
  localparam logic [19:0] addr_data_ready_0 = 20'h107d0;
  localparam logic [19:0] addr_data_ready_1 = 20'h107d1;
  localparam logic [19:0] addr_latency_control = 20'h107d2;
  localparam logic [19:0] addr_latency_accumulator = 20'h107d3;

  localparam int num_pair_counters = 6;
  localparam int count_lsb = 0;
  localparam int count_msb = 31;
  localparam int qual_lsb = 32;
  localparam int qual_msb = 63;
  localparam int latency_enable_bit = 26;
  localparam int weight_width = 8;

  localparam logic [31:0] reset_count = 32'h0000_0000;
  localparam logic [31:0] reset_qual = 32'h0000_0000;
  localparam logic [63:0] reset_wide = 64'h0000_0000_0000_0000;

endpackage : uncore_counters_pkg

/* File: core/count_update_if.sv */
// interface: software write strobes and data of one counter slice, one instance per slice
// assumes all users run on the same system clock
`timescale 1ns/1ps
interface count_update_if;
  logic wr_lo;
  logic wr_hi;
  logic [31:0] wr_data_lo;
  logic [31:0] wr_data_hi;
  logic [63:0] value;
  modport master (output wr_lo, output wr_hi, output wr_data_lo, output wr_data_hi,
    input value);
  modport slice (input wr_lo, input wr_hi, input wr_data_lo, input wr_data_hi,
    output value);
endinterface : count_update_if

/* File: core/qualified_counter.sv */
// module: one event register, qualification half above a 32-bit counter half
// assumes event pulses arrive on the system clock
`timescale 1ns/1ps
module qualified_counter
  import uncore_counters_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // event and register access
  input wire logic event_in,
  count_update_if.slice upd
);

  logic [31:0] qual;
  logic [31:0] count;
  logic [31:0] next_qual;
  logic [31:0] next_count;

  always_comb
  begin
    next_qual = qual;
    next_count = count;
    if (upd.wr_hi)
    begin
      next_qual = upd.wr_data_hi;
    end
    if (upd.wr_lo)
    begin
      next_count = upd.wr_data_lo;
    end
    else if ((qual != reset_qual) && event_in)
    begin
      next_count = count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      qual <= reset_qual;
      count <= reset_count;
    end
    else
    begin
      qual <= next_qual;
      count <= next_count;
    end
  end

  assign upd.value = {qual, count};

endmodule : qualified_counter

/* File: core/uncore_bus_event_counters.sv */
// module: bank of bus queue, snoop queue, data-ready and latency event counters
// assumes one 64-bit model register access per cycle from the core, same clock
// Functional notes
// - Four facilities exist: bus queue, snoop queue, data-ready and latency accumulation.
// - Every register serves exactly one facility and none is shared.
// - Bits 63:32 of each bus queue register hold its qualification and enable controls.
// - Bits 31:0 of each bus queue register are a 32-bit counter of qualified events.
// - A bus queue counter runs once its upper half is written with any nonzero value.
// - A bus queue counter freezes once its upper half is written with zero.
// - The two snoop queue registers split the same way, controls above a 32-bit counter.
// - A snoop queue counter starts on a nonzero upper half and freezes on a zero one.
// - The two data-ready registers count in the low half once any upper bit is set.
// - The latency facility adds weighted cycle counts of bus queue transactions.
// - Latency accumulation runs while bit 26 of the latency control register is one.
// - Writing zero to that bit freezes the latency accumulator at its value.
// - The latency accumulator is a full 64-bit counter.
`timescale 1ns/1ps
module uncore_bus_event_counters
  import uncore_counters_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // model register access from the core
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [19:0] reg_addr_in,
  input wire logic [63:0] reg_wdata_in,
  output logic [63:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic reg_hit_out,
  // event pulses from the units
  input wire logic [1:0] bus_queue_event_in,
  input wire logic [1:0] snoop_queue_event_in,
  input wire logic [1:0] data_ready_event_in,
  input wire logic [weight_width-1:0] latency_weight_in,
  // status
  output logic [3:0] facility_running_out
);

  // latency facility
  logic [63:0] latency_ctl;
  logic [63:0] next_latency_ctl;
  logic [63:0] latency_acc;
  logic [63:0] next_latency_acc;
  logic [63:0] latency_step;
  // read answer
  logic [63:0] rdata;
  logic [63:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic hit;
  logic next_hit;
  // facility status
  logic [3:0] running;
  logic [3:0] next_running;
  // address decode
  logic sel_latency_ctl;
  logic sel_latency_acc;
  logic sel_any;
  // counter slices
  logic [num_pair_counters-1:0] slice_event;
  logic [num_pair_counters-1:0] slice_sel;
  logic [num_pair_counters-1:0] slice_enabled;
  logic [63:0] slice_value [num_pair_counters];
  logic [19:0] slice_addr [num_pair_counters];

  // slice order: bus queue 0/1, snoop queue 0/1, data-ready 0/1
  assign slice_event = {data_ready_event_in, snoop_queue_event_in, bus_queue_event_in};
  assign slice_addr[0] = addr_bus_queue_0;
  assign slice_addr[1] = addr_bus_queue_1;
  assign slice_addr[2] = addr_snoop_queue_0;
  assign slice_addr[3] = addr_snoop_queue_1;
  assign slice_addr[4] = addr_data_ready_0;
  assign slice_addr[5] = addr_data_ready_1;

  genvar gi;
  generate
    for (gi = 0; gi < num_pair_counters; gi++)
    begin : g_slice
      count_update_if upd ();
      // each slice decodes only its own address
      assign slice_sel[gi] = (reg_addr_in == slice_addr[gi]);
      // whole 64-bit write loads both halves
      assign upd.wr_hi = reg_write_in && slice_sel[gi];
      assign upd.wr_lo = reg_write_in && slice_sel[gi];
      assign upd.wr_data_hi = reg_wdata_in[qual_msb:qual_lsb];
      assign upd.wr_data_lo = reg_wdata_in[count_msb:count_lsb];
      assign slice_value[gi] = upd.value;
      assign slice_enabled[gi] = (upd.value[qual_msb:qual_lsb] != reset_qual);
      // counter runs while its qualification half is nonzero
      qualified_counter u_counter (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .event_in(slice_event[gi]),
        .upd(upd.slice)
      );
    end
  endgenerate

  // address decode of the two latency registers and of the whole bank
  assign sel_latency_ctl = (reg_addr_in == addr_latency_control);
  assign sel_latency_acc = (reg_addr_in == addr_latency_accumulator);
  assign sel_any = (|slice_sel) || sel_latency_ctl || sel_latency_acc;

  // weight added to the latency accumulator per enabled cycle
  assign latency_step = {{(64 - weight_width){1'b0}}, latency_weight_in};

  // latency control: whole word stored, only the enable bit acts
  always_comb
  begin
    next_latency_ctl = latency_ctl;
    if (reg_write_in && sel_latency_ctl)
    begin
      next_latency_ctl = reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      latency_ctl <= reset_wide;
    end
    else
    begin
      latency_ctl <= next_latency_ctl;
    end
  end

  // latency accumulator: a software write wins over the weighted add
  always_comb
  begin
    next_latency_acc = latency_acc;
    if (reg_write_in && sel_latency_acc)
    begin
      next_latency_acc = reg_wdata_in;
    end
    else if (latency_ctl[latency_enable_bit])
    begin
      next_latency_acc = latency_acc + latency_step;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      latency_acc <= reset_wide;
    end
    else
    begin
      latency_acc <= next_latency_acc;
    end
  end

  // read data: stands one cycle after the read request, zero otherwise
  always_comb
  begin
    next_rdata = 64'h0000_0000_0000_0000;
    if (reg_read_in)
    begin
      for (int i = 0; i < num_pair_counters; i++)
      begin
        if (slice_sel[i])
        begin
          next_rdata = slice_value[i];
        end
      end
      if (sel_latency_ctl)
      begin
        next_rdata = latency_ctl;
      end
      if (sel_latency_acc)
      begin
        next_rdata = latency_acc;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata <= reset_wide;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // read valid: one pulse per read request
  always_comb
  begin
    next_rvalid = reg_read_in;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= next_rvalid;
    end
  end

  // read hit: mapped addresses only, unmapped reads answer zero
  always_comb
  begin
    next_hit = reg_read_in && sel_any;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      hit <= 1'b0;
    end
    else
    begin
      hit <= next_hit;
    end
  end

  // facility status: one bit per facility, one cycle behind the registers
  always_comb
  begin
    next_running = 4'h0;
    for (int f = 0; f < num_pair_counters / 2; f++)
    begin
      next_running[f] = slice_enabled[2 * f] || slice_enabled[2 * f + 1];
    end
    next_running[3] = latency_ctl[latency_enable_bit];
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      running <= 4'h0;
    end
    else
    begin
      running <= next_running;
    end
  end

  assign reg_rdata_out = rdata;
  assign reg_rvalid_out = rvalid;
  assign reg_hit_out = hit;
  assign facility_running_out = running;

endmodule : uncore_bus_event_counters

/* File: verification/uncore_counters_checker.sv */
// checker: port timing of register reads and counter enables of the bank
// assumes it is bound to the bank top module on the system clock
`timescale 1ns/1ps
module uncore_counters_checker
  import uncore_counters_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // register access and status
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [19:0] reg_addr_in,
  input wire logic [63:0] reg_wdata_in,
  input wire logic [63:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic reg_hit_out,
  input wire logic [3:0] facility_running_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  logic mapped;
  assign mapped = reg_addr_in >= addr_bus_queue_0 && reg_addr_in <= addr_latency_accumulator;
  sequence wr_at(a, c);
    reg_write_in && reg_addr_in == a && c ##1 !reg_write_in;
  endsequence
  sequence freeze_then_read;
    reg_write_in && mapped && reg_addr_in < addr_latency_control && reg_wdata_in[63:32] == 32'h0
    ##1 !reg_write_in ##1 reg_read_in && !reg_write_in && reg_addr_in == $past(reg_addr_in, 2);
  endsequence
  a_read_answer: assert property (
    reg_read_in |=> reg_rvalid_out && reg_hit_out == $past(mapped)) else $error("bad read answer");
  a_no_stray_answer: assert property (
    !reg_read_in |=> !reg_rvalid_out && reg_rdata_out == 64'h0) else $error("stray read answer");
  a_unmapped_zero: assert property (
    reg_read_in && !mapped |=> reg_rdata_out == 64'h0) else $error("unmapped data not zero");
  a_bus_queue_start: assert property (
    wr_at(addr_bus_queue_0, reg_wdata_in[63:32] != 32'h0) |=> facility_running_out[0])
    else $error("bus queue not running");
  a_snoop_start: assert property (
    wr_at(addr_snoop_queue_0, reg_wdata_in[63:32] != 32'h0) |=> facility_running_out[1])
    else $error("snoop queue not running");
  a_ready_start: assert property (
    wr_at(addr_data_ready_0, reg_wdata_in[63:32] != 32'h0) |=> facility_running_out[2])
    else $error("data-ready not running");
  a_latency_on: assert property (
    wr_at(addr_latency_control, reg_wdata_in[latency_enable_bit]) |=> facility_running_out[3])
    else $error("latency not running");
  a_latency_off: assert property (
    wr_at(addr_latency_control, !reg_wdata_in[latency_enable_bit]) |=> !facility_running_out[3])
    else $error("latency still running");
  a_frozen_readback: assert property (
    freeze_then_read |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("frozen value moved");
endmodule : uncore_counters_checker
bind uncore_bus_event_counters uncore_counters_checker u_chk (.clk_sys_in, .resetn_in,
  .reg_write_in, .reg_read_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
  .reg_rvalid_out, .reg_hit_out, .facility_running_out);

/* File: verification/core_access_model.sv */
// model: core issuing whole 64-bit model register reads and writes
// assumes the bank answers a read exactly one cycle after the request
`timescale 1ns/1ps
module core_access_model
(
  // clock
  input wire logic clk_sys_in,
  // requests toward the bank
  output logic reg_write_out = 1'b0,
  output logic reg_read_out = 1'b0,
  output logic [19:0] reg_addr_out = 20'h00000,
  output logic [63:0] reg_wdata_out = 64'h0,
  // answer from the bank
  input wire logic [63:0] reg_rdata_in,
  input wire logic reg_rvalid_in,
  input wire logic reg_hit_in
);
  task automatic write_reg(input logic [19:0] a, input logic [63:0] d);
    @(posedge clk_sys_in);
    reg_write_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clk_sys_in);
    reg_write_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [19:0] a, output logic [64:0] r, output logic v);
    @(posedge clk_sys_in);
    reg_read_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clk_sys_in);
    reg_read_out <= 1'b0;
    reg_addr_out <= ~a;
    @(negedge clk_sys_in);
    r = {reg_hit_in, reg_rdata_in};
    v = reg_rvalid_in;
  endtask : read_reg
endmodule : core_access_model

/* File: verification/testbench.sv */
// testbench: counter bank driven by the core model and event pulses
// assumes a 100 MHz clock and zero reset values
`timescale 1ns/1ps
module testbench
  import uncore_counters_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [7:0] weight = 8'h03;
  logic wr, rd_req, rvalid, hit;
  logic [19:0] addr;
  logic [63:0] wdata, rdata;
  logic [3:0] running;
  int error_cnt = 0;
  int compares = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  core_access_model CORE (.clk_sys_in(clk_sys_in), .reg_write_out(wr), .reg_read_out(rd_req),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_hit_in(hit));
  uncore_bus_event_counters DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .reg_write_in(wr), .reg_read_in(rd_req), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .reg_hit_out(hit),
    .bus_queue_event_in(ev[1:0]), .snoop_queue_event_in(ev[3:2]),
    .data_ready_event_in(ev[5:4]), .latency_weight_in(weight), .facility_running_out(running));
  task automatic rd(input logic [19:0] a, input logic [64:0] exp);
    logic [64:0] r;
    logic v;
    CORE.read_reg(a, r, v);
    compares++;
    if ({v, r} !== {1'b1, exp})
    begin
      error_cnt++;
      $display("[FAIL] register %h expected %h seen %h", a, {1'b1, exp}, {v, r});
    end
  endtask : rd
  task automatic pulse(input int n);
    @(posedge clk_sys_in);
    ev <= 6'h3f;
    repeat (n) @(posedge clk_sys_in);
    ev <= 6'h00;
  endtask : pulse
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    logic [19:0] a;
    logic [31:0] q;
    repeat (16) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    CORE.write_reg(20'h107d4, 64'hffff_ffff_ffff_ffff);
    for (int i = 0; i < 8; i++)
      rd(addr_bus_queue_0 + 20'(i), {1'b1, 64'h0});
    rd(20'h107d4, 65'h0);
    $display("test reset and map done");
    for (int i = 0; i < num_pair_counters; i++)
    begin
      a = addr_bus_queue_0 + 20'(i);
      q = 32'h1 << (5 * i);
      CORE.write_reg(a, {q, 32'h0});
      pulse(5);
      rd(a, {1'b1, q, 32'h5});
      CORE.write_reg(a, {32'h0, 32'h5});
      rd(a, {1'b1, 32'h0, 32'h5});
      pulse(3);
      rd(a, {1'b1, 32'h0, 32'h5});
      CORE.write_reg(a, {q, 32'h5});
      pulse(2);
      rd(a, {1'b1, q, 32'h7});
      CORE.write_reg(a, {32'h0, 32'h7});
    end
    $display("test pair counters done");
    CORE.write_reg(addr_latency_accumulator, 64'h0000_0000_ffff_fffe);
    CORE.write_reg(addr_latency_control, 64'h0000_0000_0400_0000);
    repeat (8) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    compares++;
    if (running !== 4'h8)
    begin
      error_cnt++;
      $display("[FAIL] facility_running_out expected %h seen %h", 4'h8, running);
    end
    CORE.write_reg(addr_latency_control, 64'hffff_ffff_fbff_ffff);
    rd(addr_latency_control, {1'b1, 64'hffff_ffff_fbff_ffff});
    rd(addr_latency_accumulator, {1'b1, 64'h0000_0001_0000_001c});
    rd(addr_latency_accumulator, {1'b1, 64'h0000_0001_0000_001c});
    $display("test latency done");
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd(addr_latency_accumulator, {1'b1, 64'h0});
    rd(addr_data_ready_1, {1'b1, 64'h0});
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : testbench
